//--- rtl/link_pkg.sv
// constants, state types and the crc step for the serial network link
// assumes a single 125 MHz system clock and a two-level serial line
//
// Summary of operation
// - a zero bit is a line transition, a one bit is no transition
// - bits go out at 2 Mbps within 0.01 percent
// - after five ones of frame content a zero is inserted
// - a zero following five content ones is removed on receive
// - delimiter is zero, six ones, zero; opens and closes every frame
// - runs of seven or more ones are never sent nor taken as commands
// - at least one opening delimiter sent; repeated openers are accepted
// - responses are accepted whatever their address byte holds
// - command frames carry the ones complement of the address next
// - last data byte makes the byte sum of the frame zero
// - content ends with three residual bits for nodes, five for devices
// - 16-bit crc x16+x12+x5+1, preset to ones, sent inverted
// - frame is good only when the receive crc residue is f0b8
// - crc covers all bits between delimiters except inserted zeros; check field is two bytes
// - at least one closing delimiter sent; repeated closers are accepted
// - receive sampling realigns only after 4 us without transitions
// - first edge after quiet is a bit boundary; sample 0.25 us on, then 0.5 us
// - sample point within 0.125 us; local timing held to 0.01 percent
// - sampling stays within 12.5 percent of mid-bit over 128 byte frames
// - only this end originates command frames; units only answer
// - line driver enable stays asserted, never high impedance
// - line low for 4 us is idle, high for 4 us is stuck
// - a frame starts with the rising edge of a full delimiter
// - after a full closing delimiter the line is driven low
`default_nettype none

package link_pkg;

    // timing, in nanoseconds, and the derived cycle counts
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_TIME_NS = 500;
    localparam int SAMPLE_DELAY_NS = 250;
    localparam int QUIET_TIME_NS = 4000;
    localparam logic [5:0] BIT_CYC_SHORT = 6'(BIT_TIME_NS / CLK_PERIOD_NS);
    localparam logic [5:0] SAMPLE_CYC = 6'(SAMPLE_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [8:0] QUIET_CYC =
        9'((QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // framing
    localparam logic [7:0] FLAG_BYTE = 8'h7e;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] FLAG_RUN = 3'h6;
    localparam logic [2:0] ABORT_RUN = 3'h7;
    localparam logic [1:0] OPEN_FLAGS = 2'h1;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] FCS_BITS = 5'h10;
    localparam logic [4:0] RESID_NODE = 5'h03;
    localparam logic [4:0] RESID_DEVICE = 5'h05;
    localparam logic [11:0] MIN_BODY_BITS = 12'h010;
    localparam logic [11:0] RX_CNT_MAX = 12'hfff;

    // check field
    localparam logic [15:0] CRC_PRESET = 16'hffff;
    localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hf0b8;

    typedef enum logic [6:0] {
        TX_IDLE = 7'h01,
        TX_OPEN = 7'h02,
        TX_BODY = 7'h04,
        TX_RESID = 7'h08,
        TX_FCS = 7'h10,
        TX_CLOSE = 7'h20,
        TX_QUIET = 7'h40
    } tx_state_t;

    typedef enum logic [3:0] {
        PH_CTRL = 4'h1,
        PH_DATA = 4'h2,
        PH_SUM = 4'h4,
        PH_DONE = 4'h8
    } phase_t;

    // one bit of the lsb-first crc
    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                             input logic din);
        logic fb;
        fb = crc[0] ^ din;
        crc_step = {1'b0, crc[15:1]} ^ (fb ? CRC_POLY_REFL : 16'h0000);
    endfunction

endpackage

`default_nettype wire

//--- rtl/io_sequencer_link.sv
// sequencer end of the serial network link: command frame sender and
// response frame receiver with nrzi coding and receive timing recovery
// assumes the line input is asynchronous and the user side runs on sys_clk
`default_nettype none
`timescale 1ns/100ps

module io_sequencer_link
    import link_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // network line
    input wire logic rx_line_in,
    output logic tx_line_out,
    output logic tx_line_oe,
    // command frame source
    input wire logic tx_start,
    input wire logic tx_cmd_frame,
    input wire logic tx_to_device,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_busy,
    // response frame sink
    input wire logic rx_to_device,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_first,
    output logic rx_end,
    output logic rx_crc_ok,
    output logic rx_sum_ok,
    output logic rx_len_ok,
    // line state
    output logic link_idle,
    output logic link_stuck
);

    // transmit state
    tx_state_t tx_state_reg;
    phase_t phase_reg;
    logic [15:0] tx_sr_reg;
    logic [4:0] tx_left_reg;
    logic [2:0] tx_ones_reg;
    logic [1:0] flag_cnt_reg;
    logic [5:0] tx_timer_reg;
    logic tx_alt_reg;
    logic [15:0] tx_crc_reg;
    logic [7:0] tx_sum_reg;
    logic [7:0] addr_reg;
    logic cmd_reg;
    logic dev_reg;
    logic last_reg;
    logic [8:0] tx_quiet_reg;
    logic tx_line_reg;
    logic tx_oe_reg;
    logic tx_ready_reg;
    logic tx_busy_reg;

    // receive state
    logic rx_meta_reg;
    logic rx_s2_reg;
    logic rx_s3_reg;
    logic [8:0] qcnt_reg;
    logic rx_sync_reg;
    logic [5:0] stimer_reg;
    logic rx_alt_reg;
    logic last_smp_reg;
    logic [2:0] rx_ones_reg;
    logic in_frame_reg;
    logic [6:0] dl_reg;
    logic [2:0] dcnt_reg;
    logic [29:0] csr_reg;
    logic [11:0] rx_cnt_reg;
    logic [15:0] rx_crc_reg;
    logic [7:0] rx_sum_reg;
    logic [7:0] rx_data_reg;
    logic rx_valid_reg;
    logic rx_first_reg;
    logic rx_end_reg;
    logic rx_crc_ok_reg;
    logic rx_sum_ok_reg;
    logic rx_len_ok_reg;
    logic link_idle_reg;
    logic link_stuck_reg;

    // byte sitting just behind the held tail of the content stream
    function automatic logic [7:0] pick_byte(input logic [29:0] sr,
                                             input logic [11:0] tail);
        logic [7:0] b;
        int i;
        b = 8'h00;
        for (i = 0; i < 8; i++)
        begin
            b[i] = sr[int'(tail) + 7 - i];
        end
        pick_byte = b;
    endfunction

    // transmit decoding
    wire tx_tick = (tx_state_reg != TX_IDLE) && (tx_timer_reg == 6'h00);
    wire tx_content = (tx_state_reg == TX_BODY) ||
                      (tx_state_reg == TX_RESID) || (tx_state_reg == TX_FCS);
    wire stuff_now = tx_content && (tx_ones_reg == STUFF_RUN);
    wire unit_done = (tx_left_reg == 5'h00);
    wire send_bit = tx_tick && !stuff_now && !unit_done;
    wire tx_emit = send_bit || (tx_tick && stuff_now);
    wire tx_bit = stuff_now ? 1'b0 : tx_sr_reg[0];
    wire crc_en = send_bit &&
                  ((tx_state_reg == TX_BODY) || (tx_state_reg == TX_RESID));
    wire load_unit = unit_done && !tx_tick;
    wire start_ok = (tx_state_reg == TX_IDLE) && tx_start && tx_valid;
    wire take_data = load_unit && (tx_state_reg == TX_BODY) &&
                     (phase_reg == PH_DATA) && tx_valid && !last_reg;
    wire [7:0] sum_check = 8'h00 - tx_sum_reg;
    wire [5:0] tx_reload = BIT_CYC_SHORT - 6'h01 + {5'h00, tx_alt_reg};

    // bit timer alternates 62 and 63 cycles for an exact 500 ns mean
    always_ff @(posedge sys_clk)
    begin
        if (reset || tx_state_reg == TX_IDLE)
        begin
            tx_timer_reg <= 6'h00;
            tx_alt_reg <= 1'b0;
        end
        else if (tx_tick)
        begin
            tx_timer_reg <= tx_reload;
            tx_alt_reg <= ~tx_alt_reg;
        end
        else
            tx_timer_reg <= tx_timer_reg - 6'h01;
    end

    // line level, driver enable, zero insertion and crc
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            tx_line_reg <= 1'b0;
            tx_oe_reg <= 1'b1;
            tx_ones_reg <= 3'h0;
            tx_crc_reg <= CRC_PRESET;
        end
        else
        begin
            tx_oe_reg <= 1'b1;
            if (tx_state_reg == TX_CLOSE && unit_done && tx_tick)
                tx_line_reg <= 1'b0;
            else if (tx_emit && !tx_bit)
                tx_line_reg <= ~tx_line_reg;
            if (tx_emit)
                tx_ones_reg <= (tx_content && tx_bit) ?
                               tx_ones_reg + 3'h1 : 3'h0;
            if (start_ok)
                tx_crc_reg <= CRC_PRESET;
            else if (crc_en)
                tx_crc_reg <= crc_step(tx_crc_reg, tx_bit);
        end
    end

    // frame sequencer: loads each unit when the previous one is spent
    always_ff @(posedge sys_clk)
    begin
        tx_ready_reg <= 1'b0;
        if (reset)
        begin
            tx_state_reg <= TX_IDLE;
            phase_reg <= PH_CTRL;
            tx_sr_reg <= 16'h0000;
            tx_left_reg <= 5'h00;
            flag_cnt_reg <= 2'h0;
            tx_sum_reg <= 8'h00;
            addr_reg <= 8'h00;
            cmd_reg <= 1'b0;
            dev_reg <= 1'b0;
            last_reg <= 1'b0;
            tx_quiet_reg <= 9'h000;
        end
        else
        begin
            if (send_bit)
            begin
                tx_sr_reg <= {1'b0, tx_sr_reg[15:1]};
                tx_left_reg <= tx_left_reg - 5'h01;
            end
            case (tx_state_reg)
                TX_IDLE:
                begin
                    if (start_ok)
                    begin
                        tx_state_reg <= TX_OPEN;
                        tx_sr_reg <= {8'h00, FLAG_BYTE};
                        tx_left_reg <= BYTE_BITS;
                        flag_cnt_reg <= 2'h1;
                        cmd_reg <= tx_cmd_frame;
                        dev_reg <= tx_to_device;
                    end
                end
                TX_OPEN:
                begin
                    if (load_unit && flag_cnt_reg < OPEN_FLAGS)
                    begin
                        tx_sr_reg <= {8'h00, FLAG_BYTE};
                        tx_left_reg <= BYTE_BITS;
                        flag_cnt_reg <= flag_cnt_reg + 2'h1;
                    end
                    else if (load_unit)
                    begin
                        tx_state_reg <= TX_BODY;
                        tx_sr_reg <= {8'h00, tx_data};
                        tx_left_reg <= BYTE_BITS;
                        tx_ready_reg <= 1'b1;
                        addr_reg <= tx_data;
                        tx_sum_reg <= tx_data;
                        last_reg <= tx_last;
                        phase_reg <= tx_cmd_frame ? PH_CTRL : PH_DATA;
                    end
                end
                TX_BODY:
                begin
                    if (load_unit)
                    begin
                        tx_left_reg <= BYTE_BITS;
                        case (phase_reg)
                            PH_CTRL:
                            begin
                                tx_sr_reg <= {8'h00, ~addr_reg};
                                tx_sum_reg <= tx_sum_reg + ~addr_reg;
                                phase_reg <= PH_DATA;
                            end
                            PH_DATA:
                            begin
                                if (take_data)
                                begin
                                    tx_sr_reg <= {8'h00, tx_data};
                                    tx_sum_reg <= tx_sum_reg + tx_data;
                                    tx_ready_reg <= 1'b1;
                                    last_reg <= tx_last;
                                end
                                else
                                begin
                                    tx_sr_reg <= {8'h00, sum_check};
                                    phase_reg <= PH_DONE;
                                end
                            end
                            default:
                            begin
                                tx_state_reg <= TX_RESID;
                                tx_sr_reg <= 16'h0000;
                                tx_left_reg <= dev_reg ?
                                               RESID_DEVICE : RESID_NODE;
                            end
                        endcase
                    end
                end
                TX_RESID:
                begin
                    if (load_unit)
                    begin
                        tx_state_reg <= TX_FCS;
                        tx_sr_reg <= ~tx_crc_reg;
                        tx_left_reg <= FCS_BITS;
                    end
                end
                TX_FCS:
                begin
                    if (load_unit && !stuff_now)
                    begin
                        tx_state_reg <= TX_CLOSE;
                        tx_sr_reg <= {8'h00, FLAG_BYTE};
                        tx_left_reg <= BYTE_BITS;
                    end
                end
                TX_CLOSE:
                begin
                    if (unit_done && tx_tick)
                    begin
                        tx_state_reg <= TX_QUIET;
                        tx_quiet_reg <= 9'h000;
                    end
                end
                TX_QUIET:
                begin
                    if (tx_quiet_reg == QUIET_CYC)
                        tx_state_reg <= TX_IDLE;
                    else
                        tx_quiet_reg <= tx_quiet_reg + 9'h001;
                end
                default:
                    tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tx_busy_reg <= 1'b0;
        else
            tx_busy_reg <= !(tx_state_reg == TX_IDLE && !start_ok);
    end

    // receive decoding
    wire rx_edge = rx_s2_reg ^ rx_s3_reg;
    wire rx_quiet = (qcnt_reg == QUIET_CYC);
    wire sync_go = !rx_sync_reg && rx_quiet && rx_edge;
    wire rx_tick = rx_sync_reg && (stimer_reg == 6'h00);
    wire rx_bit = (rx_s2_reg == last_smp_reg);
    wire is_stuff = !rx_bit && (rx_ones_reg == STUFF_RUN);
    wire is_flag = !rx_bit && (rx_ones_reg == FLAG_RUN);
    wire is_abort = rx_bit && (rx_ones_reg >= FLAG_RUN);
    wire enter = rx_tick && in_frame_reg && !is_stuff && !is_flag;
    wire cbit = enter && (dcnt_reg == 3'h7);
    wire [29:0] csr_next = {csr_reg[28:0], dl_reg[6]};
    wire [11:0] rx_tail = 12'(BYTE_BITS) * 12'h000 + 12'(FCS_BITS) +
                          12'(rx_to_device ? RESID_DEVICE : RESID_NODE);
    wire [11:0] rx_ncnt = (rx_cnt_reg == RX_CNT_MAX) ?
                          rx_cnt_reg : rx_cnt_reg + 12'h001;
    wire [11:0] ex_next = rx_ncnt - rx_tail;
    wire [11:0] ex_now = rx_cnt_reg - rx_tail;
    wire emit_byte = cbit && (rx_ncnt >= rx_tail + 12'(BYTE_BITS)) &&
                     (ex_next[2:0] == 3'h0);
    wire [7:0] new_byte = pick_byte(csr_next, rx_tail);
    wire frame_end = rx_tick && is_flag && in_frame_reg &&
                     (rx_cnt_reg != 12'h000);

    // line synchroniser and quiet timer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rx_meta_reg <= 1'b0;
            rx_s2_reg <= 1'b0;
            rx_s3_reg <= 1'b0;
            qcnt_reg <= 9'h000;
            link_idle_reg <= 1'b0;
            link_stuck_reg <= 1'b0;
        end
        else
        begin
            rx_meta_reg <= rx_line_in;
            rx_s2_reg <= rx_meta_reg;
            rx_s3_reg <= rx_s2_reg;
            if (rx_edge)
                qcnt_reg <= 9'h000;
            else if (!rx_quiet)
                qcnt_reg <= qcnt_reg + 9'h001;
            link_idle_reg <= rx_quiet && !rx_s2_reg;
            link_stuck_reg <= rx_quiet && rx_s2_reg;
        end
    end

    // sampling clock recovery
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rx_sync_reg <= 1'b0;
            stimer_reg <= 6'h00;
            rx_alt_reg <= 1'b0;
            last_smp_reg <= 1'b0;
        end
        else if (sync_go)
        begin
            rx_sync_reg <= 1'b1;
            stimer_reg <= SAMPLE_CYC - 6'h01;
            rx_alt_reg <= 1'b0;
            last_smp_reg <= rx_s3_reg;
        end
        else if (rx_sync_reg && rx_quiet)
            rx_sync_reg <= 1'b0;
        else if (rx_tick)
        begin
            stimer_reg <= BIT_CYC_SHORT - 6'h01 + {5'h00, rx_alt_reg};
            rx_alt_reg <= ~rx_alt_reg;
            last_smp_reg <= rx_s2_reg;
        end
        else if (rx_sync_reg)
            stimer_reg <= stimer_reg - 6'h01;
    end

    // flag hunting, zero deletion and content tail
    always_ff @(posedge sys_clk)
    begin
        if (reset || (rx_sync_reg && rx_quiet))
        begin
            rx_ones_reg <= 3'h0;
            in_frame_reg <= 1'b0;
            dcnt_reg <= 3'h0;
            rx_cnt_reg <= 12'h000;
        end
        else if (rx_tick)
        begin
            rx_ones_reg <= !rx_bit ? 3'h0 :
                           (rx_ones_reg == ABORT_RUN) ? rx_ones_reg :
                           rx_ones_reg + 3'h1;
            if (is_flag)
            begin
                in_frame_reg <= 1'b1;
                dcnt_reg <= 3'h0;
                rx_cnt_reg <= 12'h000;
            end
            else if (is_abort)
                in_frame_reg <= 1'b0;
            else if (enter)
            begin
                if (dcnt_reg != 3'h7)
                    dcnt_reg <= dcnt_reg + 3'h1;
                if (cbit)
                    rx_cnt_reg <= rx_ncnt;
            end
        end
    end

    // content shift, crc and byte delivery
    always_ff @(posedge sys_clk)
    begin
        rx_valid_reg <= 1'b0;
        rx_end_reg <= 1'b0;
        if (reset)
        begin
            dl_reg <= 7'h00;
            csr_reg <= 30'h00000000;
            rx_crc_reg <= CRC_PRESET;
            rx_sum_reg <= 8'h00;
            rx_data_reg <= 8'h00;
            rx_first_reg <= 1'b0;
            rx_crc_ok_reg <= 1'b0;
            rx_sum_ok_reg <= 1'b0;
            rx_len_ok_reg <= 1'b0;
        end
        else
        begin
            if (enter)
                dl_reg <= {dl_reg[5:0], rx_bit};
            if (rx_tick && is_flag)
            begin
                rx_crc_reg <= CRC_PRESET;
                rx_sum_reg <= 8'h00;
            end
            else if (cbit)
            begin
                csr_reg <= csr_next;
                rx_crc_reg <= crc_step(rx_crc_reg, dl_reg[6]);
            end
            if (emit_byte)
            begin
                rx_data_reg <= new_byte;
                rx_valid_reg <= 1'b1;
                rx_first_reg <= (ex_next == 12'(BYTE_BITS));
                rx_sum_reg <= rx_sum_reg + new_byte;
            end
            if (frame_end)
            begin
                rx_end_reg <= 1'b1;
                rx_crc_ok_reg <= (rx_crc_reg == CRC_GOOD);
                rx_sum_ok_reg <= (rx_sum_reg == 8'h00);
                rx_len_ok_reg <= (rx_cnt_reg >= rx_tail + MIN_BODY_BITS) &&
                                 (ex_now[2:0] == 3'h0);
            end
        end
    end

    // outputs straight from flip-flops
    assign tx_line_out = tx_line_reg;
    assign tx_line_oe = tx_oe_reg;
    assign tx_ready = tx_ready_reg;
    assign tx_busy = tx_busy_reg;
    assign rx_data = rx_data_reg;
    assign rx_valid = rx_valid_reg;
    assign rx_first = rx_first_reg;
    assign rx_end = rx_end_reg;
    assign rx_crc_ok = rx_crc_ok_reg;
    assign rx_sum_ok = rx_sum_ok_reg;
    assign rx_len_ok = rx_len_ok_reg;
    assign link_idle = link_idle_reg;
    assign link_stuck = link_stuck_reg;

    // checks on the link behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    drive_enable_a: assert property (tx_oe_reg)
        else $error("line driver enable dropped");
    bit_spacing_a: assert property (tx_tick |=> !tx_tick [*8])
        else $error("transmit bit ticks too close");
    frame_rise_a: assert property (start_ok |-> ##2 tx_line_reg)
        else $error("frame did not open with a rising edge");
    stuff_limit_a: assert property (!(tx_content && tx_ones_reg > STUFF_RUN))
        else $error("six content ones sent");
    ctrl_byte_a: assert property ((tx_state_reg == TX_BODY &&
        phase_reg == PH_CTRL && load_unit) |=> tx_sr_reg[7:0] == ~addr_reg)
        else $error("control byte not address complement");
    shutdown_low_a: assert property (tx_state_reg == TX_QUIET |-> !tx_line_reg)
        else $error("line not low after closing flag");
    resync_quiet_a: assert property ($rose(rx_sync_reg) |-> $past(rx_quiet))
        else $error("receive timing realigned without quiet");
    first_sample_a: assert property ($rose(rx_sync_reg) |-> ##30 rx_tick)
        else $error("first sample not at half bit");
    crc_verdict_a: assert property (rx_end_reg |-> rx_crc_ok_reg ==
        ($past(rx_crc_reg) == CRC_GOOD))
        else $error("crc verdict wrong");

    frame_sent_c: cover property (tx_state_reg == TX_CLOSE ##1
                                  tx_state_reg == TX_QUIET);
    stuffed_c: cover property (tx_tick && stuff_now);
    good_rx_c: cover property (rx_end_reg && rx_crc_ok_reg && rx_sum_ok_reg);
    resync_c: cover property (sync_go);

endmodule // io_sequencer_link

`default_nettype wire

//--- test/unit_model.sv
// far unit model: sends response frames onto the line
// assumes sys_clk at 125 MHz; line rests low between frames
`timescale 1ns/100ps
`default_nettype none
module unit_model (
    // clock
    input wire logic sys_clk,
    // network line, always driven
    output var logic line_out,
    // command line from the sequencer
    input wire logic line_in
);
    logic [15:0] crc_reg;
    logic [15:0] fcs;
    int ones;
    bit odd;
    initial line_out = 1'b0;
    // one bit time, 62 or 63 cycles
    task automatic put_bit(input logic b);
        if (!b)
            line_out = ~line_out;
        odd = ~odd;
        repeat (62 + int'(odd)) @(negedge sys_clk);
    endtask
    // flag byte, zero six ones zero
    task automatic put_flag;
        for (int i = 0; i < 8; i++)
            put_bit(i != 0 && i != 7);
    endtask
    // content bit with crc and zero insertion
    task automatic put_body(input logic b);
        put_bit(b);
        crc_reg = {1'b0, crc_reg[15:1]}
            ^ ((crc_reg[0] ^ b) ? 16'h8408 : 16'h0000);
        ones = b ? ones + 1 : 0;
        if (ones == 5)
        begin
            put_bit(1'b0);
            ones = 0;
        end
    endtask
    // mid-bit samples of a command frame: opening flag, address, control
    task automatic take(output logic [15:0] a);
        logic p;
        p = 1'b0;
        a = 16'h0000;
        repeat (30) @(negedge sys_clk);
        for (int i = 0; i < 24; i++)
        begin
            if (i > 7)
                a[i - 8] = (line_in == p);
            p = line_in;
            repeat (62 + i % 2) @(negedge sys_clk);
        end
    endtask
    // frame: two openers, body, residual, check field, two closers
    task automatic send(input logic [31:0] body, input int n, input int rb,
        input logic spoil);
        crc_reg = 16'hffff;
        ones = 0;
        put_flag();
        put_flag();
        for (int i = 0; i < 8 * n + rb; i++)
            put_body(i < 8 * n && body[i]);
        fcs = ~crc_reg ^ {15'h0, spoil};
        for (int i = 0; i < 16; i++)
            put_body(fcs[i]);
        put_flag();
        put_flag();
        line_out = 1'b0;
        repeat (520) @(negedge sys_clk);
    endtask
endmodule // unit_model
`default_nettype wire

//--- test/tb_top.sv
// bench for the sequencer link end
// assumes the far unit model drives the receive line
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic sys_clk, reset, tx_start, tx_cmd_frame, tx_to_device;
    logic tx_valid, tx_last, rx_to_device;
    logic [7:0] tx_data;
    wire logic rx_line, tx_line_out, tx_line_oe, tx_ready, tx_busy, rx_valid;
    wire logic rx_first, rx_end, rx_crc_ok, rx_sum_ok, rx_len_ok;
    wire logic link_idle, link_stuck;
    wire logic [7:0] rx_data;
    int err_count = 0;
    int total_checks = 0;
    io_sequencer_link dut_u (.sys_clk(sys_clk), .reset(reset),
        .rx_line_in(rx_line), .tx_line_out(tx_line_out),
        .tx_line_oe(tx_line_oe), .tx_start(tx_start),
        .tx_cmd_frame(tx_cmd_frame), .tx_to_device(tx_to_device),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_to_device(rx_to_device),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
        .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .rx_sum_ok(rx_sum_ok),
        .rx_len_ok(rx_len_ok), .link_idle(link_idle),
        .link_stuck(link_stuck));
    unit_model far_u (.sys_clk(sys_clk), .line_out(rx_line),
        .line_in(tx_line_out));
    // 8 ns clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // compare and count
    task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", what, e, g);
            err_count++;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one response frame; flags are crc, sum, length expected
    task automatic run_rx(input logic [31:0] body, input int n, input int rb,
        input logic spoil, input logic [2:0] flags);
        int k;
        int t;
        k = 0;
        fork
            far_u.send(body, n, rb, spoil);
            for (t = 0; t < 9000 && rx_end !== 1'b1; t++)
            begin
                @(negedge sys_clk);
                if (rx_valid === 1'b1)
                begin
                    chk("rx_data", body[8*k+:8], rx_data);
                    chk("rx_first", 8'(k == 0), 8'(rx_first));
                    k++;
                end
            end
        join
        if (t >= 9000)
            err_count++;
        chk("rx_bytes", 8'(n), 8'(k));
        chk("rx_stat", 8'(flags),
            {5'h0, rx_crc_ok, rx_sum_ok, rx_len_ok});
        $display("rx frame done");
    endtask
    // address ff forces zero insertion
    task automatic test_rx_device;
        rx_to_device = 1'b1;
        run_rx({8'h00, 8'h85, 8'h7c, 8'hff}, 3, 5, 0, 7);
    endtask
    task automatic test_rx_node;
        rx_to_device = 1'b0;
        run_rx({8'ha8, 8'h3f, 8'hf8, 8'h21}, 4, 3, 0, 7);
    endtask
    // wrong sum and spoiled check field
    task automatic test_rx_faults;
        rx_to_device = 1'b1;
        run_rx({8'h00, 8'h10, 8'h7e, 8'h05}, 3, 5, 1, 1);
    endtask
    // command frame of address and one data byte
    task automatic test_tx;
        int t;
        int r;
        int q;
        logic [15:0] a;
        r = 0;
        q = 0;
        tx_data = 8'h5a;
        tx_valid = 1'b1;
        tx_start = 1'b1;
        @(negedge sys_clk);
        tx_start = 1'b0;
        chk("tx_busy", 8'h01, 8'(tx_busy));
        chk("tx_line", 8'h00, 8'(tx_line_out));
        @(negedge sys_clk);
        chk("tx_line", 8'h01, 8'(tx_line_out));
        fork
            far_u.take(a);
            for (t = 0; t < 9000 && tx_busy === 1'b1; t++)
            begin
                @(negedge sys_clk);
                q = (tx_line_out === 1'b0) ? q + 1 : 0;
                r += int'(tx_ready === 1'b1);
                tx_last = (r > 0);
                tx_data = (r > 0) ? 8'h3c : 8'h5a;
                tx_valid = (r < 2);
            end
        join
        if (t >= 9000)
            err_count++;
        chk("tx_addr", 8'h5a, a[7:0]);
        chk("tx_ctrl", 8'ha5, a[15:8]);
        chk("tx_taken", 8'h02, 8'(r));
        chk("tail_quiet", 8'h01, 8'(q >= 490));
        chk("tx_oe", 8'h01, 8'(tx_line_oe));
        $display("tx frame done");
    endtask
    initial
    begin
        {reset, tx_cmd_frame, tx_to_device} = 3'h7;
        {tx_start, tx_valid, tx_last, rx_to_device, tx_data} = 12'h000;
        repeat (6) @(negedge sys_clk);
        reset = 1'b0;
        chk("tx_oe", 8'h01, 8'(tx_line_oe));
        repeat (510) @(negedge sys_clk);
        chk("idle_stuck", 8'h02, {6'h0, link_idle, link_stuck});
        test_rx_device;
        test_rx_node;
        test_rx_faults;
        test_tx;
        print_verdict;
    end
endmodule // tb_top
`default_nettype wire
